// ==== hw/po_parallel_out_map.vh ====
// Register map, reset values and timing constants of the parallel output block
`ifndef PO_PARALLEL_OUT_MAP_VH
`define PO_PARALLEL_OUT_MAP_VH

// Register byte offsets
`define PO_ADDR_FORMAT    8'h00
`define PO_ADDR_POLARITY  8'h04
`define PO_ADDR_FIXED     8'h08
`define PO_ADDR_INTERVAL  8'h0c
`define PO_ADDR_PINROLE   8'h10
`define PO_ADDR_IN1_FUNC  8'h14
`define PO_ADDR_IN1_SENSE 8'h18
`define PO_ADDR_IN2_FUNC  8'h1c
`define PO_ADDR_IN2_SENSE 8'h20
`define PO_ADDR_STATUS    8'h24
`define PO_ADDR_OUTWORD   8'h28

// Status register field positions
`define PO_ST_STABLE  0
`define PO_ST_FREEZE  1
`define PO_ST_ERROR   2
`define PO_ST_IN_LSB  4

// Reset values
`define PO_RST_FORMAT   3'h0
`define PO_RST_POLARITY 1'h0
`define PO_RST_FIXED    25'h0000000
`define PO_RST_INTERVAL 14'h000a
`define PO_RST_PINROLE  4'h0
`define PO_RST_FUNC     4'h0
`define PO_RST_SENSE    2'h1

// Interval limits in milliseconds
`define PO_INTERVAL_MIN 14'h0001
`define PO_INTERVAL_MAX 14'h270f

// Timing: clock period and one millisecond, both in ns
`define PO_CLK_NS       8
`define PO_MS_NS        1000000
// Factory restore hold time in ms, one extra tick guarantees the full second
`define PO_RESTORE_MS   1000
`define PO_RESTORE_TICKS 11'h3e9

// BCD saturation limit
`define PO_BCD_MAX      25'h00f423f

`endif

// ==== hw/po_parallel_out.v ====
// Parallel output formatter with three control inputs decoded into commands
`timescale 1ns/10ps
// Function
// - Format 0,1,2 encodes processed reading as binary, Gray, BCD.
// - Format 3,4,5 encodes the stored fixed word as binary, Gray, BCD.
// - Polarity 1 inverts the parallel data lines.
// - Fixed word is signed 25 bits, default zero, written by software.
// - Output refreshes every 1 to 9999 ms, default 10 ms.
// - Pin role 0 keeps lines 25 and 24 as data.
// - Roles 1,2 put error high or low on line 25.
// - Role 3 puts error high on 25, inverted error on 24.
// - Roles 4,5 put word-valid high or low on line 25.
// - Roles 6..9 put word-valid on 25, error on 24, four polarities.
// - Role 10 puts word-valid on 25 and its complement on 24.
// - Sense 0 low level, 1 high level, 2 rising, 3 falling edge.
// - Level-only functions need level sense; edge functions fire on activation under any sense.
// - Function 1 acts by mode: counter load, SSI offset, start-stop store.
// - Function 2 freezes reading and output while asserted.
// - Function 3 in SSI mode captures the encoder zero offset.
// - Functions 4 and 5 load counter A or B in counter mode.
// - Functions 6 and 7 lock counter A or B while asserted in counter mode.
// - Function 8 clears min and max; function 0 does nothing.
// - Function 9 restores factory settings after one second held.
// - Input 2 has its own function and sense settings.
// - Input 3 is fixed to factory restore, active high level.
// - Reading source is the linked, scaled, filtered measurement.
`include "po_parallel_out_map.vh"

module po_parallel_out #(
  parameter MS_CYCLES    = `PO_MS_NS / `PO_CLK_NS,
  parameter SETTLE       = 4,
  parameter RESTORE_TICKS = `PO_RESTORE_MS + 1
) (
  // Clock and reset
  input  wire        clock,
  input  wire        rst,
  // Register port
  input  wire [7:0]  regAddr,
  input  wire [31:0] regWrData,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [31:0] regRdData,
  // Measurement side
  input  wire [24:0] processedReading,
  input  wire        errorStatus,
  input  wire [1:0]  measMode,
  // Control input pins
  input  wire [2:0]  ctrlIn,
  // Parallel lines, index 24 is line 25
  output reg  [24:0] parOut,
  // Commands to counter, SSI and start-stop units
  output reg         loadBothCounters,
  output reg         loadCounterA,
  output reg         loadCounterB,
  output reg         lockCounterA,
  output reg         lockCounterB,
  output reg         ssiOffsetCapture,
  output reg         encoderZeroCapture,
  output reg         startStopOffsetStore,
  output reg         clearMinMax,
  output reg         factoryRestore,
  output reg         freeze
);

  // Measurement modes and control functions
  localparam MODE_COUNTER = 2'h0;
  localparam MODE_SSI     = 2'h1;
  localparam MODE_STSTOP  = 2'h2;
  localparam FN_SET       = 4'h1;
  localparam FN_FREEZE    = 4'h2;
  localparam FN_ZERO      = 4'h3;
  localparam FN_SET_A     = 4'h4;
  localparam FN_SET_B     = 4'h5;
  localparam FN_LOCK_A    = 4'h6;
  localparam FN_LOCK_B    = 4'h7;
  localparam FN_MINMAX    = 4'h8;
  localparam FN_FACTORY   = 4'h9;

  // Configuration registers
  reg [2:0]  outputFormat;
  reg        output_polarity;
  reg [24:0] fixedWord;
  reg [13:0] updateInterval;
  reg [3:0]  pinRole;
  reg [3:0]  inFunc1;
  reg [1:0]  inSense1;
  reg [3:0]  inFunc2;
  reg [1:0]  inSense2;

  // Output state
  reg [24:0] dataWord;
  reg        dataStable;
  reg        loadPending;
  reg [7:0]  settleCnt;
  reg        errSeen;
  reg [16:0] msCnt;
  reg        msTick;
  reg [13:0] refreshCnt;

  // Per-input settings, input 3 fixed
  wire [11:0] funcVec  = {`PO_RST_FUNC | FN_FACTORY, inFunc2, inFunc1};
  wire [5:0]  senseVec = {2'h1, inSense2, inSense1};
  wire [2:0]  trig;
  wire [2:0]  held;
  wire [2:0]  restoreFire;
  wire [2:0]  filtLevel;

  // Binary to Gray, reflected code of the two's complement word
  function [24:0] encGray;
    input [24:0] w;
    begin
      encGray = w ^ {1'b0, w[24:1]};
    end
  endfunction

  // Sign plus six BCD digits of the magnitude, saturated at 999999
  function [24:0] encBcd;
    input [24:0] w;
    reg [24:0] m;
    reg [43:0] s;
    integer i;
    integer d;
    begin
      m = w[24] ? (~w + 25'h0000001) : w;
      if (m > `PO_BCD_MAX)
        m = `PO_BCD_MAX;
      s = {24'h000000, m[19:0]};
      for (i = 0; i < 20; i = i + 1) begin
        for (d = 0; d < 6; d = d + 1) begin
          if (s[20 + 4 * d +: 4] >= 4'h5)
            s[20 + 4 * d +: 4] = s[20 + 4 * d +: 4] + 4'h3;
        end
        s = {s[42:0], 1'b0};
      end
      encBcd = {w[24], s[43:20]};
    end
  endfunction

  // Source selection and encoding of the next data word
  reg [24:0] srcWord;
  reg [24:0] next_dataWord;
  always @* begin
    srcWord = (outputFormat >= 3'h3) ? fixedWord : processedReading;
    case (outputFormat)
      3'h0, 3'h3: next_dataWord = srcWord;
      3'h1, 3'h4: next_dataWord = encGray(srcWord);
      3'h2, 3'h5: next_dataWord = encBcd(srcWord);
      default:    next_dataWord = srcWord;
    endcase
  end

  // Control input conditioning and trigger detection, one per input
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gIn
      reg [2:0]  sync;
      reg        filt;
      reg        actPrev;
      reg [10:0] holdCnt;
      reg        fired;
      wire [1:0] sense = senseVec[2 * g +: 2];
      wire [3:0] func  = funcVec[4 * g +: 4];
      wire       act   = (sense == 2'h0 || sense == 2'h3) ? ~filt : filt;
      wire       isLvl = ~sense[1];
      // Three-stage synchroniser; level accepted once stages two and three agree
      always @(posedge clock) begin
        if (rst) begin
          sync    <= 3'h0;
          filt    <= 1'b0;
          actPrev <= 1'b0;
        end else begin
          sync <= {sync[1:0], ctrlIn[g]};
          if (sync[1] == sync[2])
            filt <= sync[2];
          actPrev <= act;
        end
      end
      // Hold timer for factory restore, counted in millisecond ticks
      always @(posedge clock) begin
        if (rst) begin
          holdCnt <= 11'h000;
          fired   <= 1'b0;
        end else if (!(act && isLvl && func == FN_FACTORY)) begin
          holdCnt <= 11'h000;
          fired   <= 1'b0;
        end else if (holdCnt == RESTORE_TICKS[10:0]) begin
          fired <= 1'b1;
        end else if (msTick) begin
          holdCnt <= holdCnt + 11'h001;
        end
      end
      assign trig[g]        = act & ~actPrev;
      assign held[g]        = act & isLvl;
      assign restoreFire[g] = (holdCnt == RESTORE_TICKS[10:0]) & ~fired;
      assign filtLevel[g]   = filt;
    end
  endgenerate

  // Command decode across all inputs
  reg next_loadBoth;
  reg next_loadA;
  reg next_loadB;
  reg next_lockA;
  reg next_lockB;
  reg next_ssiOff;
  reg next_zero;
  reg next_ssStore;
  reg next_minmax;
  reg next_restore;
  reg next_freeze;
  integer k;
  always @* begin
    next_loadBoth = 1'b0;
    next_loadA    = 1'b0;
    next_loadB    = 1'b0;
    next_lockA    = 1'b0;
    next_lockB    = 1'b0;
    next_ssiOff   = 1'b0;
    next_zero     = 1'b0;
    next_ssStore  = 1'b0;
    next_minmax   = 1'b0;
    next_restore  = 1'b0;
    next_freeze   = 1'b0;
    for (k = 0; k < 3; k = k + 1) begin
      case (funcVec[4 * k +: 4])
        FN_SET: begin
          if (trig[k] && measMode == MODE_COUNTER)
            next_loadBoth = 1'b1;
          if (trig[k] && measMode == MODE_SSI)
            next_ssiOff = 1'b1;
          if (trig[k] && measMode == MODE_STSTOP)
            next_ssStore = 1'b1;
        end
        FN_FREEZE: begin
          if (held[k])
            next_freeze = 1'b1;
        end
        FN_ZERO: begin
          if (trig[k] && measMode == MODE_SSI)
            next_zero = 1'b1;
        end
        FN_SET_A: begin
          if (trig[k] && measMode == MODE_COUNTER)
            next_loadA = 1'b1;
        end
        FN_SET_B: begin
          if (trig[k] && measMode == MODE_COUNTER)
            next_loadB = 1'b1;
        end
        FN_LOCK_A: begin
          if (held[k] && measMode == MODE_COUNTER)
            next_lockA = 1'b1;
        end
        FN_LOCK_B: begin
          if (held[k] && measMode == MODE_COUNTER)
            next_lockB = 1'b1;
        end
        FN_MINMAX: begin
          if (trig[k])
            next_minmax = 1'b1;
        end
        FN_FACTORY: begin
          if (restoreFire[k])
            next_restore = 1'b1;
        end
        default: begin
          next_freeze = next_freeze;
        end
      endcase
    end
  end

  // Command outputs, pulses last one cycle, locks and freeze are levels
  always @(posedge clock) begin
    if (rst) begin
      loadBothCounters     <= 1'b0;
      loadCounterA         <= 1'b0;
      loadCounterB         <= 1'b0;
      lockCounterA         <= 1'b0;
      lockCounterB         <= 1'b0;
      ssiOffsetCapture     <= 1'b0;
      encoderZeroCapture   <= 1'b0;
      startStopOffsetStore <= 1'b0;
      clearMinMax          <= 1'b0;
      factoryRestore       <= 1'b0;
      freeze               <= 1'b0;
    end else begin
      loadBothCounters     <= next_loadBoth;
      loadCounterA         <= next_loadA;
      loadCounterB         <= next_loadB;
      lockCounterA         <= next_lockA;
      lockCounterB         <= next_lockB;
      ssiOffsetCapture     <= next_ssiOff;
      encoderZeroCapture   <= next_zero;
      startStopOffsetStore <= next_ssStore;
      clearMinMax          <= next_minmax;
      factoryRestore       <= next_restore;
      freeze               <= next_freeze;
    end
  end

  // Millisecond tick and refresh interval counter
  always @(posedge clock) begin
    if (rst) begin
      msCnt      <= 17'h00000;
      msTick     <= 1'b0;
      refreshCnt <= 14'h0000;
    end else begin
      msTick <= 1'b0;
      if (msCnt == MS_CYCLES[16:0] - 17'h00001) begin
        msCnt  <= 17'h00000;
        msTick <= 1'b1;
      end else begin
        msCnt <= msCnt + 17'h00001;
      end
      if (msTick) begin
        if (refreshCnt >= updateInterval - 14'h0001)
          refreshCnt <= 14'h0000;
        else
          refreshCnt <= refreshCnt + 14'h0001;
      end
    end
  end

  wire refreshDue = msTick && (refreshCnt >= updateInterval - 14'h0001);

  // Word loading with word-valid handshake
  always @(posedge clock) begin
    if (rst) begin
      dataWord    <= 25'h0000000;
      dataStable  <= 1'b0;
      loadPending <= 1'b0;
      settleCnt   <= 8'h00;
      errSeen     <= 1'b0;
    end else begin
      errSeen <= errorStatus;
      if (refreshDue && !freeze) begin
        dataStable  <= 1'b0;
        loadPending <= 1'b1;
      end else if (loadPending) begin
        dataWord    <= next_dataWord;
        loadPending <= 1'b0;
        settleCnt   <= SETTLE[7:0];
      end else if (settleCnt != 8'h00) begin
        settleCnt <= settleCnt - 8'h01;
      end else begin
        dataStable <= 1'b1;
      end
    end
  end

  // Line driving with polarity and special roles of lines 25 and 24
  reg [24:0] next_parOut;
  always @* begin
    next_parOut = dataWord ^ {25{output_polarity}};
    case (pinRole)
      4'h1: next_parOut[24] = errSeen;
      4'h2: next_parOut[24] = ~errSeen;
      4'h3: next_parOut[24:23] = {errSeen, ~errSeen};
      4'h4: next_parOut[24] = dataStable;
      4'h5: next_parOut[24] = ~dataStable;
      4'h6: next_parOut[24:23] = {dataStable, errSeen};
      4'h7: next_parOut[24:23] = {dataStable, ~errSeen};
      4'h8: next_parOut[24:23] = {~dataStable, errSeen};
      4'h9: next_parOut[24:23] = {~dataStable, ~errSeen};
      4'ha: next_parOut[24:23] = {dataStable, ~dataStable};
      default: next_parOut = next_parOut;
    endcase
  end

  always @(posedge clock) begin
    if (rst)
      parOut <= 25'h0000000;
    else
      parOut <= next_parOut;
  end

  // Register writes; interval clamped into its legal range
  always @(posedge clock) begin
    if (rst) begin
      outputFormat    <= `PO_RST_FORMAT;
      output_polarity <= `PO_RST_POLARITY;
      fixedWord       <= `PO_RST_FIXED;
      updateInterval  <= `PO_RST_INTERVAL;
      pinRole         <= `PO_RST_PINROLE;
      inFunc1         <= `PO_RST_FUNC;
      inSense1        <= `PO_RST_SENSE;
      inFunc2         <= `PO_RST_FUNC;
      inSense2        <= `PO_RST_SENSE;
    end else if (regWr) begin
      case (regAddr)
        `PO_ADDR_FORMAT:   outputFormat <= regWrData[2:0];
        `PO_ADDR_POLARITY: output_polarity <= regWrData[0];
        `PO_ADDR_FIXED:    fixedWord <= regWrData[24:0];
        `PO_ADDR_INTERVAL: begin
          if (regWrData[31:0] < {18'h0, `PO_INTERVAL_MIN})
            updateInterval <= `PO_INTERVAL_MIN;
          else if (regWrData[31:0] > {18'h0, `PO_INTERVAL_MAX})
            updateInterval <= `PO_INTERVAL_MAX;
          else
            updateInterval <= regWrData[13:0];
        end
        `PO_ADDR_PINROLE:   pinRole <= regWrData[3:0];
        `PO_ADDR_IN1_FUNC:  inFunc1 <= regWrData[3:0];
        `PO_ADDR_IN1_SENSE: inSense1 <= regWrData[1:0];
        `PO_ADDR_IN2_FUNC:  inFunc2 <= regWrData[3:0];
        `PO_ADDR_IN2_SENSE: inSense2 <= regWrData[1:0];
        default: outputFormat <= outputFormat;
      endcase
    end
  end

  // Register reads, data in the cycle after the strobe, zero otherwise
  reg [31:0] next_rd;
  always @* begin
    next_rd = 32'h00000000;
    case (regAddr)
      `PO_ADDR_FORMAT:    next_rd = {29'h0, outputFormat};
      `PO_ADDR_POLARITY:  next_rd = {31'h0, output_polarity};
      `PO_ADDR_FIXED:     next_rd = {{7{fixedWord[24]}}, fixedWord};
      `PO_ADDR_INTERVAL:  next_rd = {18'h0, updateInterval};
      `PO_ADDR_PINROLE:   next_rd = {28'h0, pinRole};
      `PO_ADDR_IN1_FUNC:  next_rd = {28'h0, inFunc1};
      `PO_ADDR_IN1_SENSE: next_rd = {30'h0, inSense1};
      `PO_ADDR_IN2_FUNC:  next_rd = {28'h0, inFunc2};
      `PO_ADDR_IN2_SENSE: next_rd = {30'h0, inSense2};
      `PO_ADDR_STATUS: begin
        next_rd[`PO_ST_STABLE] = dataStable;
        next_rd[`PO_ST_FREEZE] = freeze;
        next_rd[`PO_ST_ERROR]  = errSeen;
        next_rd[`PO_ST_IN_LSB +: 3] = filtLevel;
      end
      `PO_ADDR_OUTWORD:   next_rd = {7'h0, dataWord};
      default:            next_rd = 32'h00000000;
    endcase
  end

  always @(posedge clock) begin
    if (rst)
      regRdData <= 32'h00000000;
    else if (regRd)
      regRdData <= next_rd;
    else
      regRdData <= 32'h00000000;
  end

endmodule

// ==== test/po_plc_model.sv ====
// Controller model that drives the three control pins of the block
`timescale 1ns/10ps
module po_plc_model (
  // Clock
  input  logic       clock,
  // Pin levels asked for by the bench
  input  logic [2:0] want,
  // Control pins toward the block
  output logic [2:0] ctrlIn
);
  // Pins move just after an edge and hold as long as asked
  always @(posedge clock) begin
    ctrlIn <= want;
  end
endmodule

// ==== test/po_parallel_out_properties.sv ====
// Port checks on the parallel output block
`timescale 1ns/10ps
module po_parallel_out_properties #(
  parameter MS_CYCLES     = 10,
  parameter RESTORE_TICKS = 3
) (
  // Clock and reset
  input logic        clock,
  input logic        rst,
  // Register port
  input logic [7:0]  regAddr,
  input logic        regWr,
  input logic        regRd,
  input logic [31:0] regRdData,
  // Measurement side and pins
  input logic        errorStatus,
  input logic [1:0]  measMode,
  input logic [2:0]  ctrlIn,
  input logic [24:0] parOut,
  // Commands
  input logic        loadBothCounters,
  input logic        loadCounterA,
  input logic        lockCounterA,
  input logic        lockCounterB,
  input logic        ssiOffsetCapture,
  input logic        encoderZeroCapture,
  input logic        startStopOffsetStore,
  input logic        clearMinMax,
  input logic        factoryRestore,
  input logic        freeze
);
  localparam int RHOLD = (RESTORE_TICKS - 1) * MS_CYCLES;
  logic [2:0]  prevIn;
  logic [31:0] sinceChg;
  // Cycles since any control pin last moved, saturating
  always @(posedge clock) begin
    prevIn <= ctrlIn;
    if (rst || ctrlIn != prevIn) begin
      sinceChg <= 32'h0;
    end else if (sinceChg != 32'hffffffff) begin
      sinceChg <= sinceChg + 32'h1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Freeze held with no writes and no error movement
  sequence s_frozen;
    (freeze && !regWr && $stable(errorStatus)) [*5];
  endsequence
  // Read of the fixed word
  sequence s_fixrd;
    regRd && regAddr == 8'h08;
  endsequence
  AST_FREEZE_HOLD: assert property (s_frozen |-> $stable(parOut))
    else $error("parallel lines moved while frozen");
  AST_FIXED_SIGN: assert property (s_fixrd |=> regRdData[31:25] == {7{regRdData[24]}})
    else $error("fixed word not sign extended");
  AST_FMT_WIDTH: assert property (regRd && regAddr == 8'h00 |=> regRdData[31:3] == 29'h0)
    else $error("format field too wide");
  AST_LOAD_MODE: assert property (loadBothCounters |-> $past(measMode) == 2'h0)
    else $error("counter load outside counter mode");
  AST_SSI_MODE: assert property (ssiOffsetCapture || encoderZeroCapture |-> $past(measMode) == 2'h1)
    else $error("SSI capture outside SSI mode");
  AST_SS_MODE: assert property (startStopOffsetStore |-> $past(measMode) == 2'h2)
    else $error("offset store outside start-stop mode");
  AST_LOCK_MODE: assert property (lockCounterA || lockCounterB |-> $past(measMode) == 2'h0)
    else $error("lock outside counter mode");
  AST_CMD_DELAY: assert property (clearMinMax || loadCounterA |-> sinceChg inside {[3:7]})
    else $error("command pulse not tied to pin change");
  AST_PULSE_ONE: assert property (clearMinMax |=> !clearMinMax)
    else $error("command pulse longer than one cycle");
  AST_RESTORE_HOLD: assert property (factoryRestore |-> sinceChg >= RHOLD ##1 !factoryRestore)
    else $error("factory restore before hold time");
endmodule

// ==== test/po_parallel_out_tb.sv ====
// Self-checking bench of the parallel output block
`timescale 1ns/10ps
module po_parallel_out_tb;
  localparam MS = 10;
  localparam RT = 3;
  logic        clock = 0, rst = 1, regWr = 0, regRd = 0, errorStatus = 0, pl;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0, regRdData, rd;
  logic [24:0] processedReading = 25'h0, parOut, w, x, e;
  logic [1:0]  measMode = 2'h0;
  logic [2:0]  want = 3'h0, ctrlIn, fm;
  logic [9:0]  seen;
  logic        loadBothCounters, loadCounterA, loadCounterB, lockCounterA, lockCounterB;
  logic        ssiOffsetCapture, encoderZeroCapture, startStopOffsetStore, clearMinMax;
  logic        factoryRestore, freeze;
  integer      n_errors = 0, n_tests = 0, seed = 90, i, k, n, f, s, m, ch;
  integer      t [3];
  logic [31:0] rstv [10] = '{0, 0, 0, 32'h0a, 0, 0, 1, 0, 1, 0};
  logic [24:0] corner [6] = '{25'h1000000, 25'h0ffffff, 25'd999999, 25'h1000000,
                              25'h1ffffff, 25'd1000000};
  wire  [9:0]  cmd = {loadBothCounters, loadCounterA, loadCounterB, ssiOffsetCapture,
                      encoderZeroCapture, startStopOffsetStore, clearMinMax,
                      lockCounterA, lockCounterB, freeze};

  po_parallel_out #(.MS_CYCLES(MS), .SETTLE(4), .RESTORE_TICKS(RT)) i_dut (
    .clock(clock), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .processedReading(processedReading),
    .errorStatus(errorStatus), .measMode(measMode), .ctrlIn(ctrlIn), .parOut(parOut),
    .loadBothCounters(loadBothCounters), .loadCounterA(loadCounterA),
    .loadCounterB(loadCounterB), .lockCounterA(lockCounterA), .lockCounterB(lockCounterB),
    .ssiOffsetCapture(ssiOffsetCapture), .encoderZeroCapture(encoderZeroCapture),
    .startStopOffsetStore(startStopOffsetStore), .clearMinMax(clearMinMax),
    .factoryRestore(factoryRestore), .freeze(freeze));
  po_plc_model i_plc (.clock(clock), .want(want), .ctrlIn(ctrlIn));

  // Clock at 125 MHz
  always #4 clock = ~clock;

  // Encoded word from format code and source value
  function automatic logic [24:0] enc(logic [2:0] fm, logic [24:0] y);
    int v, d;
    v = $signed(y);
    if (fm % 3 == 1) return y ^ (y >> 1);
    if (fm % 3 == 0) return y;
    if (v < 0) v = -v;
    if (v > 999999) v = 999999;
    enc = {y[24], 24'h0};
    for (d = 0; d < 6; d++) begin
      enc[4 * d +: 4] = v % 10;
      v = v / 10;
    end
  endfunction

  // Lines 25 and 24 for a pin role, data bits both one, word settled
  function automatic logic [1:0] pinExp(int r, logic e);
    case (r)
      0, 4: pinExp = 2'h3;
      1: pinExp = {e, 1'b1};
      2: pinExp = {~e, 1'b1};
      3: pinExp = {e, ~e};
      5: pinExp = 2'h1;
      6: pinExp = {1'b1, e};
      7: pinExp = {1'b1, ~e};
      8: pinExp = {1'b0, e};
      9: pinExp = {1'b0, ~e};
      default: pinExp = 2'h2;
    endcase
  endfunction

  // Commands seen for function, sense and mode
  function automatic logic [9:0] cmdExp(int f, int s, int m);
    logic lv;
    lv = s < 2;
    case (f)
      1: cmdExp = m == 0 ? 10'h200 : m == 1 ? 10'h040 : m == 2 ? 10'h010 : 10'h0;
      2: cmdExp = lv ? 10'h001 : 10'h0;
      3: cmdExp = m == 1 ? 10'h020 : 10'h0;
      4: cmdExp = m == 0 ? 10'h100 : 10'h0;
      5: cmdExp = m == 0 ? 10'h080 : 10'h0;
      6: cmdExp = (m == 0 && lv) ? 10'h004 : 10'h0;
      7: cmdExp = (m == 0 && lv) ? 10'h002 : 10'h0;
      default: cmdExp = 10'h008;
    endcase
  endfunction

  // One-cycle register write
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clock);
    regWr <= 1'b0;
  endtask

  // One-cycle register read, data taken in the following cycle
  task automatic rdr(logic [7:0] a);
    @(posedge clock);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRd <= 1'b0;
    @(negedge clock);
    rd = regRdData;
  endtask

  // Compare one value
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    #(8 * 60000);
    n_errors++;
    results;
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    wr(8'h40, 32'h5);
    for (i = 0; i < 10; i++) begin
      rdr(i < 9 ? 8'(4 * i) : 8'h40);
      chk(rd, rstv[i]);
    end
    wr(8'h0c, 32'h0);
    rdr(8'h0c);
    chk(rd, 32'h1);
    wr(8'h0c, 32'hffff);
    rdr(8'h0c);
    chk(rd, 32'h270f);
    $display("Test registers done");
    // Reading moves every cycle, so every refresh shows as a change
    wr(8'h0c, 32'h3);
    k = 0;
    w = parOut;
    for (i = 0; i < 400 && k < 3; i++) begin
      @(posedge clock);
      processedReading <= processedReading + 25'h1;
      if (parOut !== w) begin
        t[k] = i;
        k++;
      end
      w = parOut;
    end
    chk(t[2] - t[1], 3 * MS);
    $display("Test interval done");
    // Corner words first, then random words, formats and polarity
    wr(8'h0c, 32'h1);
    for (i = 0; i < 30; i++) begin
      fm = i < 6 ? i : $unsigned($random(seed)) % 6;
      pl = i < 6 ? 1'b0 : $random(seed);
      w = i < 6 ? corner[i] : $random(seed);
      x = fm > 2 ? w : ~w;
      @(posedge clock);
      processedReading <= fm > 2 ? ~w : w;
      wr(8'h08, {7'h0, x});
      wr(8'h00, {29'h0, fm});
      wr(8'h04, {31'h0, pl});
      repeat (30) @(posedge clock);
      e = enc(fm, w);
      rdr(8'h28);
      chk(rd[24:0], e);
      if (pl) e = ~e;
      chk(parOut, e);
      rdr(8'h08);
      chk(rd, {{7{x[24]}}, x});
    end
    wr(8'h04, 32'h0);
    $display("Test formats done");
    // Freeze on input 1, then walk every pin role with both error levels
    wr(8'h00, 32'h3);
    wr(8'h08, 32'h1800000);
    wr(8'h14, 32'h2);
    @(posedge clock);
    want <= 3'h1;
    repeat (40) @(posedge clock);
    wr(8'h08, 32'h0);
    repeat (30) @(posedge clock);
    chk(parOut, 32'h1800000);
    rdr(8'h24);
    chk(rd[1:0], 2'h3);
    for (i = 0; i < 22; i++) begin
      @(posedge clock);
      errorStatus <= i[0];
      wr(8'h10, i >> 1);
      repeat (4) @(posedge clock);
      chk(parOut[24:23], pinExp(i >> 1, i[0]));
    end
    wr(8'h10, 32'h0);
    @(posedge clock);
    want <= 3'h0;
    errorStatus <= 1'b0;
    $display("Test pin roles done");
    // Functions 1 to 8, every sense and mode, on inputs 1 and 2
    for (ch = 0; ch < 2; ch++)
      for (f = 1; f < 9; f++)
        for (s = 0; s < 4; s++)
          for (m = 0; m < 4; m++) begin
            wr(8'h14, 32'h0);
            wr(8'h1c, 32'h0);
            wr(8'h18 + 8 * ch, s);
            @(posedge clock);
            want <= (s == 0 || s == 3) ? 3'(1 << ch) : 3'h0;
            measMode <= m;
            repeat (10) @(posedge clock);
            wr(8'h14 + 8 * ch, f);
            repeat (8) @(posedge clock);
            want <= want ^ 3'(1 << ch);
            seen = 10'h0;
            n = 0;
            repeat (20) begin
              @(posedge clock);
              seen = seen | cmd;
              n = n + $countones(cmd[9:3]);
            end
            chk(seen, cmdExp(f, s, m));
            chk(n, $countones(cmdExp(f, s, m) >> 3));
            want <= want ^ 3'(1 << ch);
            repeat (12) @(posedge clock);
            chk(cmd, 10'h0);
          end
    wr(8'h1c, 32'h0);
    $display("Test commands done");
    // Input 3 long and short, then input 1 restore with level and edge sense
    for (i = 0; i < 4; i++) begin
      wr(8'h14, i < 2 ? 32'h0 : 32'h9);
      wr(8'h18, i == 3 ? 32'h2 : 32'h1);
      @(posedge clock);
      want <= i < 2 ? 3'h4 : 3'h1;
      n = 0;
      t[0] = 0;
      for (k = 0; k < (i == 1 ? 10 : 60); k++) begin
        @(posedge clock);
        if (factoryRestore === 1'b1) begin
          n++;
          t[0] = k;
        end
      end
      want <= 3'h0;
      repeat (10) @(posedge clock);
      chk(n, i == 0 || i == 2);
      if (n == 1) chk(t[0] >= (RT - 1) * MS - 2 && t[0] <= RT * MS + 12, 1);
    end
    $display("Test restore done");
    results;
  end
endmodule

bind po_parallel_out po_parallel_out_properties #(
  .MS_CYCLES(MS_CYCLES), .RESTORE_TICKS(RESTORE_TICKS)) i_props (
  .clock(clock), .rst(rst), .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData), .errorStatus(errorStatus), .measMode(measMode), .ctrlIn(ctrlIn),
  .parOut(parOut), .loadBothCounters(loadBothCounters), .loadCounterA(loadCounterA),
  .lockCounterA(lockCounterA), .lockCounterB(lockCounterB),
  .ssiOffsetCapture(ssiOffsetCapture), .encoderZeroCapture(encoderZeroCapture),
  .startStopOffsetStore(startStopOffsetStore), .clearMinMax(clearMinMax),
  .factoryRestore(factoryRestore), .freeze(freeze));
